// ---- design/flc_consts.vh ----
`ifndef FLC_CONSTS_VH
`define FLC_CONSTS_VH
// Clock and flash timing.
`define FLC_CLK_HZ 10000000
`define FLC_FLASH_STEP_MS 16
`define FLC_FLASH_STEP_CYC ((`FLC_CLK_HZ / 1000) * `FLC_FLASH_STEP_MS)
// General purpose control bit positions.
`define FLC_GP_TORCH 0
`define FLC_GP_CHARGE 1
`define FLC_GP_FLASH 2
`define FLC_GP_CM_LO 3
`define FLC_GP_CM_HI 4
`define FLC_GP_GATE 5
`define FLC_GP_SENSE_EN 6
`define FLC_GP_IND_EN 7
`define FLC_GP_RESET 8'h00
// Current control bit positions and reset value.
`define FLC_CC_TORCH_MSB 2
`define FLC_CC_RESET 8'hF8
// Options bit positions and reset value.
`define FLC_OPT_SLE 7
`define FLC_OPT_RESET 8'h80
// Charge level codes.
`define FLC_CM_OPTIMAL 2'b00
// Torch cap level while charging (60 mA) and flash scale (70 percent).
`define FLC_TORCH_CAP 3'h0
`define FLC_SCALE_PCT 7'h46
`define FLC_FULL_PCT 7'h64
`endif

// ---- design/flc_sync2.v ----
`timescale 1ns/1ps
// Two flip-flop synchroniser for a bus of asynchronous levels.
module flc_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire arst_n_i,
    // Data
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
        end else begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
        end
    end
    assign q_o = s2_ff;
endmodule // flc_sync2

// ---- design/flc_mode_ctrl.v ----
`timescale 1ns/1ps
`include "flc_consts.vh"
module flc_mode_ctrl #(
    parameter FLASH_STEP_CYC = `FLC_FLASH_STEP_CYC
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire arst_n_i,
    // Host register writes
    input wire gp_wr_i,
    input wire [7:0] gp_wdata_i,
    input wire cc_wr_i,
    input wire [7:0] cc_wdata_i,
    input wire opt_wr_i,
    input wire [7:0] opt_wdata_i,
    // Register readback
    output wire [7:0] gp_o,
    output wire [7:0] cc_o,
    output wire [7:0] opt_o,
    // Pins and analog comparator levels
    input wire strobe_i,
    input wire sense_above_low_i,
    input wire sense_above_high_i,
    input wire cap_above_3v0_i,
    input wire cap_at_target_i,
    input wire cap_above_95pct_i,
    input wire load_above_60ma_i,
    input wire load_over_max_i,
    // Charge-done open-drain pin
    output wire charge_done_n_o,
    output wire charge_done_n_oe_o,
    // Power stage controls, indicator output and state
    output wire pump_en_o,
    output wire pump_ilimit_o,
    output wire pump_const_freq_o,
    output wire [1:0] charge_level_o,
    output wire [2:0] overhead_sel_o,
    output wire torch_sink_en_o,
    output wire [2:0] torch_level_o,
    output wire flash_en_o,
    output wire [2:0] flash_level_o,
    output wire [6:0] flash_scale_pct_o,
    output wire indicator_output_o,
    output wire [2:0] state_o
);
    localparam ST_SHUTDOWN = 3'd0;
    localparam ST_TORCH = 3'd1;
    localparam ST_CHARGE = 3'd2;
    localparam ST_CHG_TORCH = 3'd3;
    localparam ST_FLASH = 3'd4;

    reg [7:0] gp_ff;
    reg [7:0] cc_ff;
    reg [7:0] opt_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [31:0] fl_cnt_ff;
    reg by_bit_ff;
    reg by_level_ff;
    reg strobe_d_ff;
    reg done_ff;
    reg reached_ff;
    reg pump_on_ff;
    reg optimal_halt_ff;
    reg level_hold_ff;

    wire strobe_s;
    wire above_low_s;
    wire above_high_s;
    wire v3_s;
    wire tgt_s;
    wire p95_s;
    wire ld60_s;
    wire ldmax_s;

    // Every pin and comparator level is asynchronous to the clock.
    // They share one synchroniser so that all of them see the same latency.
    wire [7:0] raw_lvl;
    wire [7:0] sync_lvl;

    assign raw_lvl[7] = strobe_i;
    assign raw_lvl[6] = sense_above_low_i;
    assign raw_lvl[5] = sense_above_high_i;
    assign raw_lvl[4] = cap_above_3v0_i;
    assign raw_lvl[3] = cap_at_target_i;
    assign raw_lvl[2] = cap_above_95pct_i;
    assign raw_lvl[1] = load_above_60ma_i;
    assign raw_lvl[0] = load_over_max_i;

    flc_sync2 #(
        .W(8)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(raw_lvl),
        .q_o(sync_lvl)
    );

    // Only the second flip-flop of the synchroniser is read from here on.
    assign strobe_s = sync_lvl[7];
    assign above_low_s = sync_lvl[6];
    assign above_high_s = sync_lvl[5];
    assign v3_s = sync_lvl[4];
    assign tgt_s = sync_lvl[3];
    assign p95_s = sync_lvl[2];
    assign ld60_s = sync_lvl[1];
    assign ldmax_s = sync_lvl[0];

    // Flash duration limit in cycles from the four-bit field.
    function [31:0] flash_limit;
        input [3:0] fd;
        begin
            flash_limit = ({28'h000_0000, fd} + 32'h0000_0001) * FLASH_STEP_CYC;
        end
    endfunction

    wire sense_en = gp_ff[`FLC_GP_SENSE_EN];
    wire sense_high = sense_en & above_high_s & above_low_s;
    wire sense_mid = sense_en & above_low_s & ~above_high_s;
    wire optimal = ({gp_ff[`FLC_GP_CM_HI], gp_ff[`FLC_GP_CM_LO]} == `FLC_CM_OPTIMAL);
    wire strobe_rise = strobe_s & ~strobe_d_ff;
    wire level_mode = opt_ff[`FLC_OPT_SLE];
    wire flash_allowed = (done_ff | gp_ff[`FLC_GP_GATE]) & ~sense_high;
    // A level strobe that outlives the timeout must not start a second flash.
    wire strobe_req = level_mode ? (strobe_s & ~level_hold_ff) : strobe_rise;
    wire bit_req = gp_ff[`FLC_GP_FLASH];
    wire timeout = (fl_cnt_ff + 32'h0000_0001) >= flash_limit(opt_ff[3:0]);
    wire flash_end = (state_ff == ST_FLASH) &&
                     (timeout || (by_level_ff && !strobe_s));
    wire charging = (state_ff == ST_CHARGE) || (state_ff == ST_CHG_TORCH);

    // Mode decode from the control bits.
    always @* begin
        nxt_state = ST_SHUTDOWN;
        case (state_ff)
            ST_FLASH: begin
                if (!flash_end) begin
                    nxt_state = ST_FLASH;
                end else if (!by_bit_ff && gp_ff[`FLC_GP_CHARGE] && !optimal) begin
                    nxt_state = gp_ff[`FLC_GP_TORCH] ? ST_CHG_TORCH : ST_CHARGE;
                end else if (!by_bit_ff && !gp_ff[`FLC_GP_CHARGE] && gp_ff[`FLC_GP_TORCH]) begin
                    nxt_state = ST_TORCH;
                end else if (by_bit_ff && gp_ff[`FLC_GP_CHARGE] && !optimal) begin
                    nxt_state = ST_CHARGE;
                end else begin
                    nxt_state = ST_SHUTDOWN;
                end
            end
            default: begin
                if ((bit_req || strobe_req) && flash_allowed) begin
                    nxt_state = ST_FLASH;
                end else if (gp_ff[`FLC_GP_CHARGE] && !optimal_halt_ff) begin
                    nxt_state = gp_ff[`FLC_GP_TORCH] ? ST_CHG_TORCH : ST_CHARGE;
                end else if (gp_ff[`FLC_GP_TORCH]) begin
                    nxt_state = ST_TORCH;
                end else begin
                    nxt_state = ST_SHUTDOWN;
                end
            end
        endcase
    end

    // State register and strobe edge history.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= ST_SHUTDOWN;
            strobe_d_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            strobe_d_ff <= strobe_s;
        end
    end

    // Flash length counter and a record of what started the flash.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fl_cnt_ff <= 32'h0000_0000;
            by_bit_ff <= 1'b0;
            by_level_ff <= 1'b0;
        end else if (state_ff != ST_FLASH && nxt_state == ST_FLASH) begin
            fl_cnt_ff <= 32'h0000_0000;
            by_bit_ff <= bit_req;
            by_level_ff <= ~bit_req & level_mode;
        end else if (state_ff == ST_FLASH) begin
            fl_cnt_ff <= fl_cnt_ff + 32'h0000_0001;
        end
    end

    // Charging stays halted after an optimal-mode flash until the host writes the general purpose register again.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            optimal_halt_ff <= 1'b0;
        end else if (flash_end && optimal) begin
            optimal_halt_ff <= 1'b1;
        end else if (gp_wr_i) begin
            optimal_halt_ff <= 1'b0;
        end
    end

    // Remembers a flash that ended while the strobe was still high.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            level_hold_ff <= 1'b0;
        end else if (!strobe_s) begin
            level_hold_ff <= 1'b0;
        end else if (flash_end) begin
            level_hold_ff <= 1'b1;
        end
    end

    // Host writes; hardware clears take priority over a same-cycle write.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gp_ff <= `FLC_GP_RESET;
            cc_ff <= `FLC_CC_RESET;
            opt_ff <= `FLC_OPT_RESET;
        end else begin
            if (gp_wr_i) begin
                gp_ff <= gp_wdata_i;
            end
            if (flash_end && by_bit_ff) begin
                gp_ff[`FLC_GP_FLASH] <= 1'b0;
                gp_ff[`FLC_GP_TORCH] <= 1'b0;
            end
            if (cc_wr_i) begin
                cc_ff <= cc_wdata_i;
            end
            if (state_ff == ST_CHG_TORCH && reached_ff && !tgt_s) begin
                cc_ff[`FLC_CC_TORCH_MSB] <= 1'b0;
            end
            if (opt_wr_i) begin
                opt_ff <= opt_wdata_i;
            end
        end
    end

    // Target-reached memory and the charge-done flag.
    // The flag survives a flash so that a sag below 95 percent still releases it.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_ff <= 1'b0;
            reached_ff <= 1'b0;
        end else begin
            if (charging && tgt_s) begin
                reached_ff <= 1'b1;
            end else if (!charging && state_ff != ST_FLASH) begin
                reached_ff <= 1'b0;
            end
            if (state_ff == ST_SHUTDOWN || state_ff == ST_TORCH) begin
                done_ff <= 1'b0;
            end else if (!p95_s) begin
                done_ff <= 1'b0;
            end else if (charging && tgt_s) begin
                done_ff <= 1'b1;
            end
        end
    end

    // Pulsed regulation: the pump stops at the target and starts again once
    // the capacitor sags below the turn-on threshold.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pump_on_ff <= 1'b0;
        end else if (tgt_s) begin
            pump_on_ff <= 1'b0;
        end else if (!p95_s || !v3_s) begin
            pump_on_ff <= 1'b1;
        end
    end

    wire pulsed = (state_ff == ST_TORCH) || (charging && optimal);
    wire fixed_hold = charging && !optimal && reached_ff && tgt_s;
    wire fixed_cf = fixed_hold && ld60_s && !ldmax_s;
    wire fixed_burst = fixed_hold && !ld60_s;

    // Pump operating mode: pulsed, constant frequency, burst or current limit.
    // A load above the maximum drops out of constant frequency into current limit.
    reg pump_en_c;
    reg pump_ilimit_c;
    always @* begin
        pump_en_c = 1'b0;
        pump_ilimit_c = 1'b0;
        if (pulsed) begin
            pump_en_c = pump_on_ff;
            pump_ilimit_c = 1'b1;
        end else if (fixed_burst) begin
            pump_en_c = pump_on_ff;
        end else if (fixed_cf) begin
            pump_en_c = 1'b1;
        end else if (charging) begin
            pump_en_c = 1'b1;
            pump_ilimit_c = 1'b1;
        end
    end
    assign pump_en_o = pump_en_c;
    assign pump_ilimit_o = pump_ilimit_c;
    assign pump_const_freq_o = fixed_cf;
    assign charge_level_o = {gp_ff[`FLC_GP_CM_HI], gp_ff[`FLC_GP_CM_LO]};
    assign overhead_sel_o = opt_ff[6:4];

    assign torch_sink_en_o = v3_s & ((state_ff == ST_TORCH) || (state_ff == ST_CHG_TORCH) ||
                             (state_ff == ST_CHARGE && optimal));
    assign torch_level_o = (state_ff == ST_CHG_TORCH && !reached_ff) ?
                           `FLC_TORCH_CAP : cc_ff[2:0];

    assign flash_en_o = (state_ff == ST_FLASH);
    assign flash_level_o = cc_ff[7:5];
    assign flash_scale_pct_o = sense_mid ? `FLC_SCALE_PCT : `FLC_FULL_PCT;

    assign indicator_output_o = gp_ff[`FLC_GP_IND_EN];
    assign charge_done_n_o = 1'b0;
    assign charge_done_n_oe_o = done_ff;
    assign gp_o = gp_ff;
    assign cc_o = cc_ff;
    assign opt_o = opt_ff;
    assign state_o = state_ff;
endmodule // flc_mode_ctrl

// ---- verif/flc_mode_ctrl_sva.sv ----
`timescale 1ns/1ps
module flc_mode_ctrl_sva #(
    parameter FLASH_STEP_CYC = 10
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire arst_n_i,
    // Register view and comparator levels
    input wire [7:0] gp_o,
    input wire [7:0] opt_o,
    input wire sense_above_high_i,
    input wire cap_above_3v0_i,
    // Outputs under watch
    input wire charge_done_n_o,
    input wire charge_done_n_oe_o,
    input wire pump_en_o,
    input wire torch_sink_en_o,
    input wire flash_en_o,
    input wire [6:0] flash_scale_pct_o,
    input wire indicator_output_o,
    input wire [2:0] state_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_pin_open_drain: assert property (charge_done_n_o == 1'b0)
        else $error("charge done pin drives high");
    a_torch_flag_high: assert property ((state_o == 3'd1) [*3] |-> !charge_done_n_oe_o)
        else $error("charge done flag low in torch state");
    a_ind_follow: assert property ($stable(gp_o[7]) |-> indicator_output_o == gp_o[7])
        else $error("indicator differs from its enable");
    a_flash_gate: assert property ($rose(flash_en_o) |-> gp_o[5] || $past(charge_done_n_oe_o))
        else $error("flash began before charge done");
    a_sense_block: assert property ($rose(flash_en_o) && gp_o[6] |-> !$past(sense_above_high_i, 3))
        else $error("flash began in high sense region");
    a_edge_len: assert property ($rose(flash_en_o) && !opt_o[7] |-> flash_en_o [*8])
        else $error("edge flash ended too soon");
    a_bit_clear: assert property ($fell(flash_en_o) && $past(gp_o[2]) |-> !gp_o[2] && !gp_o[0])
        else $error("mode bits kept after flash");
    a_sink_needs_3v: assert property (torch_sink_en_o |->
        $past(cap_above_3v0_i, 2) || $past(cap_above_3v0_i, 3))
        else $error("torch sink on below 3V");
    a_quiet_idle: assert property (gp_o[2:0] == 3'b000 && state_o == 3'd0 |->
        !pump_en_o && !flash_en_o && !torch_sink_en_o)
        else $error("power stage active in shutdown");
    a_scale_full: assert property ($rose(flash_en_o) && !gp_o[6] |-> flash_scale_pct_o == 7'h64)
        else $error("scaled flash with sensing off");
endmodule // flc_mode_ctrl_sva
bind flc_mode_ctrl flc_mode_ctrl_sva #(.FLASH_STEP_CYC(FLASH_STEP_CYC)) u_sva (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .gp_o(gp_o), .opt_o(opt_o),
    .sense_above_high_i(sense_above_high_i), .cap_above_3v0_i(cap_above_3v0_i),
    .charge_done_n_o(charge_done_n_o), .charge_done_n_oe_o(charge_done_n_oe_o),
    .pump_en_o(pump_en_o), .torch_sink_en_o(torch_sink_en_o), .flash_en_o(flash_en_o),
    .flash_scale_pct_o(flash_scale_pct_o), .indicator_output_o(indicator_output_o),
    .state_o(state_o));

// ---- verif/flc_cam_model.sv ----
`timescale 1ns/1ps
module flc_cam_model (
    // Bench control
    input wire logic fire_i,
    input wire logic [3:0] width_i,
    // Pins
    input wire logic done_oe_i,
    output logic done_pin_o,
    output logic strobe_o
);
    // The pull-up sets the high level whenever the pin is released.
    assign done_pin_o = done_oe_i ? 1'b0 : 1'b1;
    initial strobe_o = 1'b0;
    // Strobe pulses last whole 800 ns camera clock periods.
    always @(posedge fire_i) begin
        #800;
        strobe_o = 1'b1;
        repeat (width_i) #800;
        strobe_o = 1'b0;
    end
endmodule // flc_cam_model

// ---- verif/flash_led_mode_controller_test.sv ----
`timescale 1ns/1ps
module flash_led_mode_controller_test;
    logic clk, rst_n, gp_wr, cc_wr, opt_wr, fire, cap3, tgt, c95, lo, hi, ld60, ldmax;
    logic [7:0] wd;
    logic [3:0] width;
    logic [6:0] sc;
    wire [7:0] gp, cc, opt;
    wire [6:0] scale;
    wire [2:0] state, tlvl, oh, flvl;
    wire [1:0] clvl;
    wire oe, sink, flash, indicator_output, strobe, pin, dn, pump, ilim, cfreq;
    int fails = 0;
    int checked = 0;
    int n;
    flc_mode_ctrl #(.FLASH_STEP_CYC(10)) uut (
        .ref_clk_i(clk), .arst_n_i(rst_n), .gp_wr_i(gp_wr), .gp_wdata_i(wd),
        .cc_wr_i(cc_wr), .cc_wdata_i(wd), .opt_wr_i(opt_wr), .opt_wdata_i(wd),
        .gp_o(gp), .cc_o(cc), .opt_o(opt), .strobe_i(strobe),
        .sense_above_low_i(lo), .sense_above_high_i(hi), .cap_above_3v0_i(cap3),
        .cap_at_target_i(tgt), .cap_above_95pct_i(c95), .load_above_60ma_i(ld60),
        .load_over_max_i(ldmax), .charge_done_n_o(dn), .charge_done_n_oe_o(oe),
        .pump_en_o(pump), .pump_ilimit_o(ilim), .pump_const_freq_o(cfreq),
        .charge_level_o(clvl), .overhead_sel_o(oh), .torch_sink_en_o(sink),
        .torch_level_o(tlvl), .flash_en_o(flash), .flash_level_o(flvl),
        .flash_scale_pct_o(scale),
        .indicator_output_o(indicator_output), .state_o(state));
    flc_cam_model cam (.fire_i(fire), .width_i(width), .done_oe_i(oe),
        .done_pin_o(pin), .strobe_o(strobe));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task end_of_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string s, input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s exp %h got %h", s, e, g);
        end
    endtask
    task tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task wr(input int r, input logic [7:0] d);
        @(negedge clk);
        gp_wr = (r == 0);
        cc_wr = (r == 1);
        opt_wr = (r == 2);
        wd = d;
        @(negedge clk);
        {gp_wr, cc_wr, opt_wr} = 3'b000;
    endtask
    task pulse(input logic [3:0] w);
        @(negedge clk);
        width = w;
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
    endtask
    // Waits a bounded time for a flash, then counts its cycles.
    task flen;
        n = 0;
        repeat (80) if (flash !== 1'b1) @(negedge clk);
        sc = scale;
        while (flash === 1'b1 && n < 99) begin
            n++;
            @(negedge clk);
        end
    endtask
    task t_reset;
        chk("gp", gp, 8'h00);
        chk("cc", cc, 8'hF8);
        chk("opt", opt, 8'h80);
        chk("state", state, 8'h00);
        chk("done pin", pin, 8'h01);
        chk("done drive", dn, 8'h00);
        chk("flash level", flvl, 8'h07);
        chk("overhead", oh, 8'h00);
    endtask
    task t_torch;
        wr(0, 8'h01);
        tick(4);
        chk("torch state", state, 8'h01);
        chk("sink low", sink, 8'h00);
        chk("pump on", pump, 8'h01);
        {cap3, tgt, c95} = 3'b111;
        tick(5);
        chk("sink high", sink, 8'h01);
        chk("pump off", pump, 8'h00);
        chk("torch level", tlvl, 8'h00);
        chk("torch flag", pin, 8'h01);
        wr(0, 8'h80);
        tick(3);
        chk("indicator", indicator_output, 8'h01);
        chk("idle state", state, 8'h00);
    endtask
    task t_charge;
        wr(0, 8'h1A);
        tick(5);
        chk("charge state", state, 8'h02);
        chk("charge level", clvl, 8'h03);
        chk("done low", pin, 8'h00);
        chk("burst cf", cfreq, 8'h00);
        chk("burst ilim", ilim, 8'h00);
        ld60 = 1'b1;
        tick(3);
        chk("const freq", cfreq, 8'h01);
        ldmax = 1'b1;
        tick(3);
        chk("overload ilim", ilim, 8'h01);
        chk("overload cf", cfreq, 8'h00);
        {ld60, ldmax} = 2'b00;
        c95 = 1'b0;
        tick(5);
        chk("done released", pin, 8'h01);
        c95 = 1'b1;
        wr(0, 8'h00);
        tick(3);
    endtask
    // Charge-and-torch caps, torch msb clearing, then a mid-run reset.
    task t_chg_torch;
        tgt = 1'b0;
        wr(1, 8'hFF);
        wr(0, 8'h0B);
        tick(4);
        chk("chg torch state", state, 8'h03);
        chk("capped torch", tlvl, 8'h00);
        chk("chg torch sink", sink, 8'h01);
        tgt = 1'b1;
        tick(4);
        chk("full torch", tlvl, 8'h07);
        tgt = 1'b0;
        tick(4);
        chk("msb cleared", cc, 8'hFB);
        chk("lowered torch", tlvl, 8'h03);
        rst_n = 1'b0;
        tick(2);
        tgt = 1'b1;
        rst_n = 1'b1;
        tick(2);
        chk("reset cc", cc, 8'hF8);
        chk("reset gp", gp, 8'h00);
        chk("reset state", state, 8'h00);
    endtask
    task t_optimal;
        wr(0, 8'h02);
        tick(4);
        chk("optimal glow", sink, 8'h01);
        wr(0, 8'h26);
        flen;
        chk("optimal flash", n[7:0], 8'h0A);
        tick(3);
        chk("optimal halt", state, 8'h00);
        chk("optimal bits", gp, 8'h22);
    endtask
    task t_refuse;
        wr(0, 8'h04);
        flen;
        chk("refused len", n[7:0], 8'h00);
        wr(0, 8'h00);
    endtask
    task t_flash;
        wr(0, 8'h2E);
        flen;
        chk("bit flash len", n[7:0], 8'h0A);
        chk("full scale", {1'b0, sc}, 8'h64);
        tick(3);
        chk("bits cleared", gp, 8'h2A);
        chk("charge resumed", state, 8'h02);
    endtask
    task t_strobe;
        wr(2, 8'h00);
        wr(0, 8'h6A);
        lo = 1'b1;
        tick(4);
        pulse(1);
        flen;
        chk("edge len", n[7:0], 8'h0A);
        chk("mid scale", {1'b0, sc}, 8'h46);
        hi = 1'b1;
        tick(16);
        pulse(1);
        flen;
        chk("blocked len", n[7:0], 8'h00);
        {hi, lo} = 2'b00;
        tick(16);
    endtask
    task t_level;
        wr(2, 8'h81);
        pulse(1);
        flen;
        chk("level short", {7'h00, n > 4 && n < 12}, 8'h01);
        tick(10);
        pulse(4);
        flen;
        chk("level cut", n[7:0], 8'h14);
        tick(3);
        chk("no refire", flash, 8'h00);
    endtask
    initial begin
        {rst_n, gp_wr, cc_wr, opt_wr, fire, cap3, tgt, c95, lo, hi, ld60, ldmax} = '0;
        wd = 8'h00;
        width = 4'h1;
        tick(20);
        rst_n = 1'b1;
        t_reset;
        t_torch;
        t_charge;
        t_chg_torch;
        t_refuse;
        t_flash;
        t_optimal;
        t_strobe;
        t_level;
        end_of_test;
    end
    initial begin
        #2000000;
        fails++;
        end_of_test;
    end
endmodule // flash_led_mode_controller_test
